// [shared/tmr_pkg.sv]
// Purpose: constants and carrier types for the three up/down timers
// Assumes: 8-bit register fields, each in the low bits of a 32-bit word
// Notes:   timer n owns a 0x20-byte window at n * TMR_STRIDE
package tmr_pkg;

  localparam int          TMR_NUM      = 3;
  localparam int          TMR_ADDR_W   = 8;
  localparam int          TMR_TOG_NUM  = 2;
  localparam logic [1:0]  TMR_STRIDE_I = 2'd1;
  localparam int          TMR_SEL_LSB  = 5;
  localparam int          TMR_REG_LSB  = 2;

  // register index inside a timer window, byte offset is index * 4
  localparam logic [2:0]  REG_CTRL     = 3'h0;
  localparam logic [2:0]  REG_CFG      = 3'h1;
  localparam logic [2:0]  REG_CNT_LO   = 3'h2;
  localparam logic [2:0]  REG_CNT_HI   = 3'h3;
  localparam logic [2:0]  REG_CAP_LO   = 3'h4;
  localparam logic [2:0]  REG_CAP_HI   = 3'h5;

  // timer_control_reg fields
  localparam int          CTL_TF       = 7;
  localparam int          CTL_EXF      = 6;
  localparam int          CTL_EXEN     = 3;
  localparam int          CTL_RUN      = 2;
  localparam int          CTL_CSEL     = 1;
  localparam int          CTL_CPRL     = 0;

  // timer_config_reg fields
  localparam int          CFG_MODE_HI  = 4;
  localparam int          CFG_MODE_LO  = 3;
  localparam int          CFG_TOG      = 2;
  localparam int          CFG_OE       = 1;
  localparam int          CFG_DEC_EN   = 0;

  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_MIN      = 16'h0000;
  localparam logic [3:0]  DIV12_LAST   = 4'hb;
  localparam logic [2:0]  EXT8_LAST    = 3'h7;

  typedef enum logic [1:0] {
    CM_DIV12 = 2'b00,
    CM_SYS   = 2'b01,
    CM_EXT8  = 2'b10,
    CM_DIV2  = 2'b11
  } tmr_cmode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        tf;
    logic        exf;
    logic        exen;
    logic        run;
    logic        csel;
    logic        cprl;
    tmr_cmode_t  cmode;
    logic        tog;
    logic        oe;
    logic        dec_en;
  } tmr_timer_t;

  typedef struct packed {
    tmr_timer_t [TMR_NUM-1:0] tm;
    logic [3:0]               div12;
    logic                     div2;
    logic [2:0]               ext8;
    logic [2:0]               s_osc;
    logic [1:0][2:0]          s_cnt;
    logic [1:0][2:0]          s_ev;
    logic [TMR_NUM-1:0]       ovf_q;
    logic [31:0]              rdata;
  } tmr_state_t;

endpackage : tmr_pkg

// [hdl/tmr_timers.sv]
// Purpose: three 16-bit up/down timers with capture and auto-reload
// Assumes: apb slave, zero wait states, all pins asynchronous
// Notes:   instance 2 shares pins with instance 0 and has no toggle
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - each timer keeps a 16-bit count read and written as two bytes
// - timer function steps on system clock, /2, /12 or osc/8
// - counter function steps once per falling edge of the count pin
// - with decrement enabled, event pin high counts up, low counts down
// - with decrement enabled the event pin only sets direction
// - capture mode: event falling edge copies count into capture register
// - a capture sets the external flag and raises the request
// - capture mode: rolling over from 0xffff sets the overflow flag
// - capture mode down: 0x0000 wraps to 0xffff and sets overflow flag
// - capture works only with capture mode selected and run set
// - external enable low makes the event pin ignored for capture/reload
// - reload mode up: overflow sets flag and loads reload value
// - reload mode: event falling edge loads reload value when enabled
// - reload mode down: count equal to reload sets flag, loads 0xffff
// - reload mode when select bit clear, counting starts with run set
// - reload mode: external flag toggles each overflow, no request
// - toggle instances flip their output at every overflow or underflow
// - third instance has no toggle and shares the first's pins
// - overflow pulses go out as update and baud triggers, and for timers 0 and 1 also as converter triggers
// - overflow flag is never cleared by hardware, only by software
// - clock mode 00 /12, 01 system clock, 10 osc/8 synced, 11 /2
// - toggle state bit reads the output level, a write forces it
// - toggle reaches the pin only while output enable is set
module tmr_timers
  import tmr_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [TMR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [1:0]            count_input_pin,
  input  wire logic [1:0]            external_event_pin,
  input  wire logic                  osc_clk_pin,
  output logic      [TMR_TOG_NUM-1:0] toggle_pin,
  output logic      [TMR_TOG_NUM-1:0] toggle_pin_drive_n,
  output logic      [TMR_NUM-1:0]    timer_irq_req,
  output logic      [1:0]            adc_trigger,
  output logic      [TMR_NUM-1:0]    dac_trigger,
  output logic      [TMR_NUM-1:0]    uart0_baud_tick
);

  tmr_state_t         q;
  tmr_state_t         next_q;
  logic [TMR_NUM-1:0] step_v;
  logic [TMR_NUM-1:0] up_v;
  logic [TMR_NUM-1:0] evf_v;
  logic [TMR_NUM-1:0] ovf_v;
  logic [TMR_NUM-1:0] wr_any_v;
  logic [3:0]         tick;
  logic               osc_rise;
  logic               wr_en;
  logic [1:0]         sel_t;
  logic [2:0]         sel_r;

  // instance 2 borrows instance 0's pins
  function automatic int pin_of(input int idx);
    pin_of = (idx == 1) ? 1 : 0;
  endfunction : pin_of

  function automatic logic addr_ok(input logic [1:0] t,
                                   input logic [2:0] r);
    addr_ok = (t <= 2'(TMR_NUM - 1)) && (r <= REG_CAP_HI);
  endfunction : addr_ok

  function automatic logic [7:0] reg_read(input tmr_timer_t t,
                                          input logic [2:0] r);
    logic [7:0] v;
    v = REG_RST;
    case (r)
      REG_CTRL:
      begin
        v[CTL_TF]   = t.tf;
        v[CTL_EXF]  = t.exf;
        v[CTL_EXEN] = t.exen;
        v[CTL_RUN]  = t.run;
        v[CTL_CSEL] = t.csel;
        v[CTL_CPRL] = t.cprl;
      end
      REG_CFG:
      begin
        v[CFG_MODE_HI:CFG_MODE_LO] = t.cmode;
        v[CFG_TOG]  = t.tog;
        v[CFG_OE]   = t.oe;
        v[CFG_DEC_EN] = t.dec_en;
      end
      REG_CNT_LO: v = t.cnt[7:0];
      REG_CNT_HI: v = t.cnt[15:8];
      REG_CAP_LO: v = t.cap[7:0];
      REG_CAP_HI: v = t.cap[15:8];
      default:    v = REG_RST;
    endcase
    reg_read = v;
  endfunction : reg_read

  assign wr_en = psel & penable & pwrite;
  assign sel_t = paddr[TMR_SEL_LSB +: 2];
  assign sel_r = paddr[TMR_REG_LSB +: 3];

  always_comb
  begin
    int         p;
    logic       ev_lvl;
    logic       ev_fall;
    logic       cnt_fall;
    logic       hit;
    next_q   = q;
    step_v   = '0;
    up_v     = '0;
    evf_v    = '0;
    ovf_v    = '0;
    wr_any_v = '0;
    p        = 0;
    ev_lvl   = 1'b0;
    ev_fall  = 1'b0;
    cnt_fall = 1'b0;
    hit      = 1'b0;

    // two flops ahead of any use, third one only for edge detection
    next_q.s_osc = {q.s_osc[1:0], osc_clk_pin};
    for (int k = 0; k < 2; k++)
    begin
      next_q.s_cnt[k] = {q.s_cnt[k][1:0], count_input_pin[k]};
      next_q.s_ev[k]  = {q.s_ev[k][1:0], external_event_pin[k]};
    end

    // shared prescalers, free running so every timer sees one phase
    next_q.div2  = ~q.div2;
    next_q.div12 = (q.div12 == DIV12_LAST) ? 4'h0 : q.div12 + 4'h1;
    osc_rise     = q.s_osc[1] & ~q.s_osc[2];
    if (osc_rise)
    begin
      next_q.ext8 = q.ext8 + 3'h1;
    end
    tick[CM_SYS]   = 1'b1;
    tick[CM_DIV2]  = q.div2;
    tick[CM_DIV12] = (q.div12 == DIV12_LAST);
    tick[CM_EXT8]  = osc_rise && (q.ext8 == EXT8_LAST);

    for (int i = 0; i < TMR_NUM; i++)
    begin
      p        = pin_of(i);
      ev_lvl   = q.s_ev[p][1];
      ev_fall  = ~q.s_ev[p][1] & q.s_ev[p][2];
      cnt_fall = ~q.s_cnt[p][1] & q.s_cnt[p][2];
      up_v[i]  = ~q.tm[i].dec_en | ev_lvl;
      step_v[i] = q.tm[i].run &
                  (q.tm[i].csel ? cnt_fall
                                : tick[q.tm[i].cmode]);
      // decrement enable steals the pin, exen gates it, run gates events
      evf_v[i] = q.tm[i].run & q.tm[i].exen & ~q.tm[i].dec_en
                 & ev_fall;

      // software writes land first, hardware events below override
      hit = wr_en && (sel_t == 2'(i)) && addr_ok(sel_t, sel_r);
      wr_any_v[i] = hit;
      if (hit)
      begin
        case (sel_r)
          REG_CTRL:
          begin
            next_q.tm[i].tf   = pwdata[CTL_TF];
            next_q.tm[i].exf  = pwdata[CTL_EXF];
            next_q.tm[i].exen = pwdata[CTL_EXEN];
            next_q.tm[i].run  = pwdata[CTL_RUN];
            next_q.tm[i].csel = pwdata[CTL_CSEL];
            next_q.tm[i].cprl = pwdata[CTL_CPRL];
          end
          REG_CFG:
          begin
            next_q.tm[i].cmode =
              tmr_cmode_t'(pwdata[CFG_MODE_HI:CFG_MODE_LO]);
            next_q.tm[i].tog  = pwdata[CFG_TOG];
            next_q.tm[i].oe   = pwdata[CFG_OE];
            next_q.tm[i].dec_en = pwdata[CFG_DEC_EN];
          end
          REG_CNT_LO: next_q.tm[i].cnt[7:0]  = pwdata[7:0];
          REG_CNT_HI: next_q.tm[i].cnt[15:8] = pwdata[7:0];
          REG_CAP_LO: next_q.tm[i].cap[7:0]  = pwdata[7:0];
          REG_CAP_HI: next_q.tm[i].cap[15:8] = pwdata[7:0];
          default:    next_q.tm[i].cap = q.tm[i].cap;
        endcase
      end

      if (q.tm[i].cprl)
      begin
        if (step_v[i])
        begin
          ovf_v[i] = up_v[i] ? (q.tm[i].cnt == CNT_MAX)
                             : (q.tm[i].cnt == CNT_MIN);
          next_q.tm[i].cnt = up_v[i] ? q.tm[i].cnt + 16'h1
                                     : q.tm[i].cnt - 16'h1;
        end
        if (evf_v[i])
        begin
          next_q.tm[i].cap = q.tm[i].cnt;
          next_q.tm[i].exf = 1'b1;
        end
      end
      else
      begin
        if (step_v[i] && up_v[i])
        begin
          ovf_v[i] = (q.tm[i].cnt == CNT_MAX);
          next_q.tm[i].cnt = ovf_v[i] ? q.tm[i].cap
                                      : q.tm[i].cnt + 16'h1;
        end
        else if (step_v[i])
        begin
          ovf_v[i] = (q.tm[i].cnt == q.tm[i].cap);
          next_q.tm[i].cnt = ovf_v[i] ? CNT_MAX
                                      : q.tm[i].cnt - 16'h1;
        end
        if (ovf_v[i])
        begin
          next_q.tm[i].exf = ~next_q.tm[i].exf;
        end
        if (evf_v[i])
        begin
          next_q.tm[i].cnt = q.tm[i].cap;
          next_q.tm[i].exf = 1'b1;
        end
      end

      // set beats a same-cycle software clear
      if (ovf_v[i])
      begin
        next_q.tm[i].tf = 1'b1;
      end
      if (ovf_v[i] && (i < TMR_TOG_NUM))
      begin
        next_q.tm[i].tog = ~next_q.tm[i].tog;
      end
      if (i >= TMR_TOG_NUM)
      begin
        next_q.tm[i].tog = 1'b0;
      end
    end
    next_q.ovf_q = ovf_v;

    // read data is sampled in setup, so it lags the count by one cycle
    if (psel && !penable)
    begin
      next_q.rdata = addr_ok(sel_t, sel_r)
                     ? {24'h0, reg_read(q.tm[sel_t], sel_r)} : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign prdata  = q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(sel_t, sel_r);

  generate
    for (genvar g = 0; g < TMR_NUM; g++)
    begin : g_out
      // exf in reload mode is a count bit, so it raises no request
      assign timer_irq_req[g] = q.tm[g].tf
                                | (q.tm[g].exf & q.tm[g].cprl);
      assign dac_trigger[g]     = q.ovf_q[g];
      assign uart0_baud_tick[g] = q.ovf_q[g];
    end
    for (genvar g = 0; g < TMR_TOG_NUM; g++)
    begin : g_tog
      assign toggle_pin[g]         = q.tm[g].tog;
      assign toggle_pin_drive_n[g] = ~q.tm[g].oe;
    end
  endgenerate
  assign adc_trigger = q.ovf_q[1:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  generate
    for (genvar g = 0; g < TMR_NUM; g++)
    begin : g_chk
      chk_stop_hold: assert property (
        !q.tm[g].run && !wr_any_v[g] |=> $stable(q.tm[g].cnt))
        else $error("stopped timer count moved");
      chk_flag_sticky: assert property (
        q.tm[g].tf && !wr_any_v[g] |=> q.tm[g].tf)
        else $error("overflow flag cleared by hardware");
      chk_sys_tick: assert property (
        q.tm[g].run && !q.tm[g].csel && q.tm[g].cmode == CM_SYS
        && !evf_v[g] && q.tm[g].cap != CNT_MAX
        |=> q.tm[g].cnt != $past(q.tm[g].cnt))
        else $error("system clock mode did not step");
      chk_capture_copy: assert property (
        q.tm[g].cprl && evf_v[g] |=> q.tm[g].cap == $past(q.tm[g].cnt)
        && q.tm[g].exf)
        else $error("capture did not copy count");
      chk_up_step: assert property (
        step_v[g] && up_v[g] && q.tm[g].cprl && !evf_v[g]
        |=> q.tm[g].cnt == 16'($past(q.tm[g].cnt) + 16'h1))
        else $error("count did not advance by one");
      chk_down_reload: assert property (
        step_v[g] && !up_v[g] && !q.tm[g].cprl && !evf_v[g]
        && q.tm[g].cnt == q.tm[g].cap |=> q.tm[g].cnt == CNT_MAX
        && q.tm[g].tf)
        else $error("down reload missed");
      chk_dir_pin_quiet: assert property (
        q.tm[g].dec_en && !wr_any_v[g] |=> $stable(q.tm[g].cap))
        else $error("event pin acted with decrement enabled");
      chk_exf_toggle: assert property (
        ovf_v[g] && !q.tm[g].cprl && !evf_v[g] && !wr_any_v[g]
        |=> q.tm[g].exf != $past(q.tm[g].exf))
        else $error("external flag did not toggle");
      chk_trigger_out: assert property (
        ovf_v[g] |=> dac_trigger[g] && uart0_baud_tick[g]
        ##1 (!dac_trigger[g] || $past(ovf_v[g])))
        else $error("trigger pulse wrong");
    end
    for (genvar g = 0; g < TMR_TOG_NUM; g++)
    begin : g_tchk
      chk_toggle_flip: assert property (
        ovf_v[g] && !wr_any_v[g] |=> toggle_pin[g] != $past(toggle_pin[g]))
        else $error("toggle output did not flip");
      chk_oe_gate: assert property (
        !q.tm[g].oe |-> toggle_pin_drive_n[g])
        else $error("toggle driven while disabled");
    end
  endgenerate

endmodule : tmr_timers

// [tb/tmr_pins_model.sv]
// Purpose: pin side of the timers: count, event, oscillator, toggle pad
// Assumes: bench sets pin levels; oscillator runs free, period 30 ns
// Notes:   toggle pad has a pull-down, so an undriven pad reads 0
`timescale 1ns/1ps
module tmr_pins_model
(
  input  wire logic [1:0] cnt_lvl,
  input  wire logic [1:0] ev_lvl,
  input  wire logic [1:0] toggle_pin,
  input  wire logic [1:0] toggle_pin_drive_n,
  output logic      [1:0] count_input_pin,
  output logic      [1:0] external_event_pin,
  output logic            osc_clk_pin,
  output logic      [1:0] toggle_pad
);
  assign count_input_pin    = cnt_lvl;
  assign external_event_pin = ev_lvl;
  // pad follows the toggle only while its driver is on
  assign toggle_pad         = toggle_pin & ~toggle_pin_drive_n;
  initial
  begin
    osc_clk_pin = 1'b0;
    // offset keeps oscillator edges away from pclk edges
    #2;
    forever #15 osc_clk_pin = ~osc_clk_pin;
  end
endmodule : tmr_pins_model

// [tb/updown_timer_capture_reload_bench.sv]
// Purpose: self-checking bench for the three up/down timers
// Assumes: apb master, pins driven through the pin model
// Notes:   rate checks allow two counts for prescaler phase
`timescale 1ns/1ps
module updown_timer_capture_reload_bench
  import tmr_pkg::*;
();
  typedef struct packed {
    logic [2:0] r;
    logic [7:0] d;
    logic [7:0] e;
    logic       x;
  } tmr_row_t;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [1:0]  cnt_lvl = 2'b11;
  logic [1:0]  ev_lvl  = 2'b01;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, osc_clk_pin;
  logic [1:0]  count_input_pin, external_event_pin, toggle_pad;
  logic [1:0]  toggle_pin, toggle_pin_drive_n, adc_trigger;
  logic [2:0]  timer_irq_req, dac_trigger, uart0_baud_tick;
  logic [7:0]  e;
  int          df;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          dv [4]       = '{12, 1, 24, 2};
  tmr_row_t    rows [9]     = '{
    '{REG_CNT_LO, 8'h5a, 8'h5a, 1'b0}, '{REG_CNT_HI, 8'ha5, 8'ha5, 1'b0},
    '{REG_CAP_LO, 8'h3c, 8'h3c, 1'b0}, '{REG_CAP_HI, 8'hc3, 8'hc3, 1'b0},
    '{REG_CFG, 8'hff, 8'h1f, 1'b0},    '{REG_CFG, 8'h00, 8'h00, 1'b0},
    '{REG_CTRL, 8'hf3, 8'hc3, 1'b0},   '{REG_CTRL, 8'h00, 8'h00, 1'b0},
    '{3'h6, 8'hff, 8'h00, 1'b1}};

  tmr_timers tmr_timers_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .count_input_pin,
    .external_event_pin, .osc_clk_pin, .toggle_pin, .toggle_pin_drive_n,
    .timer_irq_req, .adc_trigger, .dac_trigger, .uart0_baud_tick);
  tmr_pins_model tmr_pins_model_inst (.cnt_lvl, .ev_lvl, .toggle_pin,
    .toggle_pin_drive_n, .count_input_pin, .external_event_pin,
    .osc_clk_pin, .toggle_pad);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // hang guard, whole run needs under two thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  function automatic logic [7:0] ra(input int t, input logic [2:0] r);
    return {1'b0, t[1:0], r, 2'b00};
  endfunction : ra

  // idle edge at the end so back-to-back calls never reassign psel
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input int t, input logic [2:0] r, input logic [7:0] d);
    apb(1'b1, ra(t, r), d);
  endtask : wr

  task automatic w16(input int t, input logic [2:0] r,
                     input logic [15:0] v);
    wr(t, r, v[7:0]);
    wr(t, r + 3'h1, v[15:8]);
  endtask : w16

  task automatic rc(input int t, input logic [2:0] r, input logic [7:0] x);
    apb(1'b0, ra(t, r), 8'h00);
    chk(rd, {24'h0, x});
  endtask : rc

  task automatic wait_ovf(input int i);
    int n;
    n = 0;
    while (dac_trigger[i] !== 1'b1 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, dac_trigger[i]}, 32'h1);
  endtask : wait_ovf

  // pin changes need three edges of sync before the block reacts
  task automatic fall(input logic ev);
    if (ev)
      ev_lvl[0] <= 1'b0;
    else
      cnt_lvl[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    ev_lvl[0] <= 1'b1;
    cnt_lvl[0] <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : fall

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({toggle_pin_drive_n, toggle_pin, timer_irq_req}), 32'h60);
    for (int t = 0; t < 3; t++)
      for (int r = 0; r < 6; r++)
        rc(t, r[2:0], 8'h00);
    for (int t = 0; t < 3; t++)
      foreach (rows[i])
      begin
        e = rows[i].e;
        if (t == 2 && rows[i].r == REG_CFG)
          e[CFG_TOG] = 1'b0;
        wr(t, rows[i].r, rows[i].d);
        rc(t, rows[i].r, e);
        chk({31'h0, err}, {31'h0, rows[i].x});
      end
    apb(1'b1, 8'h60, 8'hff);
    rc(3, REG_CTRL, 8'h00);
    chk({31'h0, err}, 32'h1);
    w16(0, REG_CAP_LO, 16'h8000);
    w16(0, REG_CNT_LO, 16'hfffe);
    wr(0, REG_CFG, 8'h0a);
    wr(0, REG_CTRL, 8'h04);
    wait_ovf(0);
    chk({30'h0, adc_trigger[0], uart0_baud_tick[0]}, 32'h3);
    chk({31'h0, toggle_pad[0]}, 32'h1);
    rc(0, REG_CTRL, 8'hc4);
    chk({31'h0, timer_irq_req[0]}, 32'h1);
    rc(0, REG_CNT_HI, 8'h80);
    wr(0, REG_CTRL, 8'h04);
    rc(0, REG_CTRL, 8'h04);
    wr(0, REG_CTRL, 8'h00);
    wr(0, REG_CFG, 8'h04);
    chk({31'h0, toggle_pad[0]}, 32'h0);
    wr(0, REG_CFG, 8'h06);
    chk({31'h0, toggle_pad[0]}, 32'h1);
    wr(0, REG_CFG, 8'h02);
    chk({31'h0, toggle_pad[0]}, 32'h0);
    w16(1, REG_CAP_LO, 16'h0010);
    w16(1, REG_CNT_LO, 16'h0014);
    wr(1, REG_CFG, 8'h09);
    wr(1, REG_CTRL, 8'h04);
    wait_ovf(1);
    chk({30'h0, adc_trigger[1], uart0_baud_tick[1]}, 32'h3);
    chk({30'h0, toggle_pin[1], toggle_pad[1]}, 32'h2);
    rc(1, REG_CNT_HI, 8'hff);
    rc(1, REG_CTRL, 8'hc4);
    wr(1, REG_CTRL, 8'h00);
    ev_lvl[1] <= 1'b1;
    w16(1, REG_CAP_LO, 16'h1234);
    w16(1, REG_CNT_LO, 16'h0008);
    wr(1, REG_CTRL, 8'h0d);
    ev_lvl[1] <= 1'b0;
    wait_ovf(1);
    rc(1, REG_CNT_HI, 8'hff);
    rc(1, REG_CTRL, 8'h8d);
    rc(1, REG_CAP_LO, 8'h34);
    wr(1, REG_CTRL, 8'h00);
    w16(2, REG_CNT_LO, 16'hffff);
    wr(2, REG_CFG, 8'h08);
    wr(2, REG_CTRL, 8'h05);
    wait_ovf(2);
    chk({31'h0, uart0_baud_tick[2]}, 32'h1);
    rc(2, REG_CTRL, 8'h85);
    w16(0, REG_CNT_LO, 16'hbeef);
    // counter mode first: a running timer's step beats a count write
    wr(2, REG_CTRL, 8'h0f);
    w16(2, REG_CNT_LO, 16'h1357);
    wr(0, REG_CTRL, 8'h07);
    fall(1'b1);
    rc(0, REG_CAP_LO, 8'h00);
    rc(2, REG_CAP_LO, 8'h57);
    rc(2, REG_CAP_HI, 8'h13);
    rc(2, REG_CTRL, 8'h4f);
    chk({31'h0, timer_irq_req[2]}, 32'h1);
    wr(2, REG_CTRL, 8'h00);
    wr(0, REG_CTRL, 8'h06);
    repeat (3) fall(1'b0);
    rc(0, REG_CNT_LO, 8'hf2);
    wr(0, REG_CTRL, 8'h0b);
    fall(1'b1);
    rc(0, REG_CAP_LO, 8'h00);
    w16(0, REG_CAP_LO, 16'h1100);
    wr(0, REG_CTRL, 8'h0e);
    fall(1'b1);
    rc(0, REG_CNT_HI, 8'h11);
    rc(0, REG_CTRL, 8'h4e);
    chk({31'h0, timer_irq_req[0]}, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      wr(0, REG_CFG, {3'h0, m[1:0], 3'h0});
      wr(0, REG_CNT_LO, 8'h00);
      wr(0, REG_CTRL, 8'h04);
      repeat (240) @(posedge pclk);
      wr(0, REG_CTRL, 8'h00);
      apb(1'b0, ra(0, REG_CNT_LO), 8'h00);
      // 240 idle edges plus the edges of the two control writes
      df = int'(rd[7:0]) - 243 / dv[m];
      chk({31'h0, df inside {[-2:2]}}, 32'h1);
    end
    wr(0, REG_CNT_LO, 8'haa);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(0, REG_CNT_LO, 8'h00);
    rc(0, REG_CAP_HI, 8'h00);
    end_of_test();
  end
endmodule : updown_timer_capture_reload_bench
